// *** logic/chp_cfg.svh ***
`ifndef CHP_CFG_SVH
`define CHP_CFG_SVH

// timing
`define CHP_MCLK_HZ 25000000
`define CHP_BIN_DLY_US 200
`define CHP_BIN_DLY_CYC ((`CHP_BIN_DLY_US) * ((`CHP_MCLK_HZ) / 1000000))

// sizes
`define CHP_NUM_BINS 9
`define CHP_NUM_EVT 5
`define CHP_ADDR_W 5

// register byte offsets
`define CHP_REG_CTRL 5'h00
`define CHP_REG_STATUS 5'h04
`define CHP_REG_RESULT 5'h08
`define CHP_REG_IRQ_STAT 5'h0c
`define CHP_REG_IRQ_MASK 5'h10
`define CHP_REG_COUNT 5'h14

// control fields
`define CHP_CTRL_AUX 0
`define CHP_CTRL_EXT_EN 1
`define CHP_CTRL_SW_TRIG 2
`define CHP_CTRL_RST 2'h2

// status fields
`define CHP_ST_BUSY 0
`define CHP_ST_CONV 1
`define CHP_ST_LOCKED 2
`define CHP_ST_TRIG_LVL 3

// result fields
`define CHP_RES_BIN_LSB 0
`define CHP_RES_BIN_MSB 3
`define CHP_RES_P_HI 4
`define CHP_RES_P_LO 5
`define CHP_RES_S_OVER 6

// event bits, shared by irq status and mask
`define CHP_EVT_TRIG 0
`define CHP_EVT_CONV 1
`define CHP_EVT_DONE 2
`define CHP_EVT_TRIG_IGN 3
`define CHP_EVT_KEY_REF 4
`define CHP_IRQ_MASK_RST 5'h00

`endif

// *** logic/chp_pkg.sv ***
package chp_pkg;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CONV = 4'b0010,
        ST_MATH = 4'b0100,
        ST_HOLD = 4'b1000
    } chp_state_t;

    typedef logic [3:0] chp_bin_t;

endpackage

// *** logic/chp_evt_irq.sv ***
`timescale 1ns/1ns
module chp_evt_irq #(
    parameter int N = 5
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // events and software access
    input wire logic [N-1:0] evt,
    input wire logic clr_we,
    input wire logic [N-1:0] clr_data,
    input wire logic [N-1:0] mask_q,
    // state
    output logic [N-1:0] status_q,
    output logic irq_q
);

    generate
        for (genvar i = 0; i < N; i++) begin : g_bit
            // a new event beats a clear in the same cycle
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    status_q[i] <= 1'b0;
                end else if (evt[i]) begin
                    status_q[i] <= 1'b1;
                end else if (clr_we && clr_data[i]) begin
                    status_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & mask_q);
        end
    end

endmodule

// *** logic/chp_handler_port.sv ***
// Chosen here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ns
`include "chp_cfg.svh"
module chp_handler_port
    import chp_pkg::*;
#(
    parameter int BIN_DLY_CYC = `CHP_BIN_DLY_CYC,
    parameter int NUM_BINS = `CHP_NUM_BINS
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [`CHP_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    // measurement core
    output logic meas_start,
    input wire logic conv_done,
    input wire logic result_valid,
    input wire logic [3:0] result_bin,
    input wire logic result_p_hi,
    input wire logic result_p_lo,
    input wire logic result_s_over,
    // front panel keys
    input wire logic key_strobe,
    input wire logic [7:0] key_code,
    output logic key_strobe_out,
    output logic [7:0] key_code_out,
    // handler pins
    input wire logic ext_trigger_in,
    input wire logic keypad_lock_n,
    output logic [NUM_BINS-1:0] sort_bin_n,
    output logic secondary_over_fail_n,
    output logic primary_over_fail_n,
    output logic primary_upper_fail_n,
    output logic primary_lower_fail_n,
    output logic overall_fail_n,
    output logic conversion_busy_n,
    output logic measure_done_n
);

    generate
        if (BIN_DLY_CYC < 1 || BIN_DLY_CYC > 65535) begin : g_chk_dly
            $error("BIN_DLY_CYC must be 1..65535");
        end
        if (NUM_BINS < 1 || NUM_BINS > 15) begin : g_chk_bins
            $error("NUM_BINS must be 1..15");
        end
    endgenerate

    chp_state_t state_q;
    logic trig_prev_q;
    logic [1:0] ctrl_q;
    logic sw_trig_q;
    logic wait_q;
    logic [31:0] rdata_q;
    logic [`CHP_NUM_EVT-1:0] mask_q;
    logic [`CHP_NUM_EVT-1:0] irq_stat;
    logic irq_int;
    logic [15:0] dly_q;
    logic [15:0] meas_cnt_q;
    chp_bin_t res_bin_q;
    logic res_p_hi_q;
    logic res_p_lo_q;
    logic res_s_over_q;
    logic start_q;
    logic key_out_q;
    logic [7:0] key_code_q;
    logic [NUM_BINS-1:0] bin_n_q;
    logic s_over_n_q;
    logic p_over_n_q;
    logic p_hi_n_q;
    logic p_lo_n_q;
    logic ng_n_q;
    logic index_n_q;
    logic eom_n_q;

    logic trig_rise;
    logic trig_req;
    logic trig_take;
    logic latch;
    logic bus_wr;
    logic bus_rd;
    logic [`CHP_NUM_EVT-1:0] evt;

    assign trig_rise = ext_trigger_in && !trig_prev_q && ctrl_q[`CHP_CTRL_EXT_EN];
    assign trig_req = trig_rise || sw_trig_q;
    assign trig_take = trig_req && (state_q == ST_IDLE);
    assign latch = (state_q == ST_MATH) && result_valid;
    // the master holds the request until waitrequest low; writes act on that edge only, reads on the cycle before it
    assign bus_wr = avs_write && !wait_q;
    assign bus_rd = avs_read && wait_q;

    // ---------------- avalon slave, one wait state ----------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wait_q <= 1'b1;
        end else if ((avs_read || avs_write) && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata_q <= 32'h0;
        end else if (bus_rd) begin
            unique case (avs_address)
                `CHP_REG_CTRL: rdata_q <= {30'h0, ctrl_q};
                `CHP_REG_STATUS: rdata_q <= {28'h0, ext_trigger_in, !keypad_lock_n,
                                             state_q == ST_CONV, state_q != ST_IDLE};
                `CHP_REG_RESULT: rdata_q <= {25'h0, res_s_over_q, res_p_lo_q, res_p_hi_q,
                                             res_bin_q};
                `CHP_REG_IRQ_STAT: rdata_q <= {27'h0, irq_stat};
                `CHP_REG_IRQ_MASK: rdata_q <= {27'h0, mask_q};
                `CHP_REG_COUNT: rdata_q <= {16'h0, meas_cnt_q};
                default: rdata_q <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl_q <= `CHP_CTRL_RST;
        end else if (bus_wr && avs_address == `CHP_REG_CTRL) begin
            ctrl_q <= avs_writedata[1:0];
        end
    end

    // software trigger is a write-one pulse, never stored
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sw_trig_q <= 1'b0;
        end else begin
            sw_trig_q <= bus_wr && avs_address == `CHP_REG_CTRL
                         && avs_writedata[`CHP_CTRL_SW_TRIG];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mask_q <= `CHP_IRQ_MASK_RST;
        end else if (bus_wr && avs_address == `CHP_REG_IRQ_MASK) begin
            mask_q <= avs_writedata[`CHP_NUM_EVT-1:0];
        end
    end

    always_comb begin
        evt = '0;
        evt[`CHP_EVT_TRIG] = trig_take;
        evt[`CHP_EVT_CONV] = (state_q == ST_CONV) && conv_done;
        evt[`CHP_EVT_DONE] = (state_q == ST_HOLD) && (dly_q == 16'h1);
        evt[`CHP_EVT_TRIG_IGN] = trig_req && (state_q != ST_IDLE);
        evt[`CHP_EVT_KEY_REF] = key_strobe && !keypad_lock_n;
    end

    chp_evt_irq #(
        .N(`CHP_NUM_EVT)
    ) u_irq (
        .mclk(mclk),
        .rst_n(rst_n),
        .evt(evt),
        .clr_we(bus_wr && avs_address == `CHP_REG_IRQ_STAT),
        .clr_data(avs_writedata[`CHP_NUM_EVT-1:0]),
        .mask_q(mask_q),
        .status_q(irq_stat),
        .irq_q(irq_int)
    );

    // ---------------- measurement sequence ----------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            trig_prev_q <= 1'b0;
        end else begin
            trig_prev_q <= ext_trigger_in;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: if (trig_take) begin
                    state_q <= ST_CONV;
                end
                ST_CONV: if (conv_done) begin
                    state_q <= ST_MATH;
                end
                ST_MATH: if (result_valid) begin
                    state_q <= ST_HOLD;
                end
                ST_HOLD: if (dly_q == 16'h1) begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // results settle on the pins for the bin delay before done is released
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dly_q <= 16'h0;
        end else if (latch) begin
            dly_q <= 16'(BIN_DLY_CYC);
        end else if (state_q == ST_HOLD && dly_q != 16'h0) begin
            dly_q <= dly_q - 16'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            start_q <= 1'b0;
        end else begin
            start_q <= trig_take;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            meas_cnt_q <= 16'h0;
        end else if (trig_take) begin
            meas_cnt_q <= meas_cnt_q + 16'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            index_n_q <= 1'b1;
        end else if (trig_take) begin
            index_n_q <= 1'b0;
        end else if (state_q == ST_CONV && conv_done) begin
            index_n_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            eom_n_q <= 1'b1;
        end else if (trig_take) begin
            eom_n_q <= 1'b0;
        end else if (state_q == ST_HOLD && dly_q == 16'h1) begin
            eom_n_q <= 1'b1;
        end
    end

    // ---------------- result latch and pins ----------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            res_bin_q <= 4'h0;
            res_p_hi_q <= 1'b0;
            res_p_lo_q <= 1'b0;
            res_s_over_q <= 1'b0;
        end else if (latch) begin
            res_bin_q <= result_bin;
            res_p_hi_q <= result_p_hi;
            res_p_lo_q <= result_p_lo;
            res_s_over_q <= result_s_over;
        end
    end

    generate
        for (genvar i = 0; i < NUM_BINS; i++) begin : g_bin
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    bin_n_q[i] <= 1'b1;
                end else if (latch) begin
                    bin_n_q[i] <= !(result_bin == 4'(i + 1));
                end
            end
        end
    endgenerate

    // aux off masks the secondary check, so the overall fail ignores it too
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_over_n_q <= 1'b1;
            p_hi_n_q <= 1'b1;
            p_lo_n_q <= 1'b1;
            p_over_n_q <= 1'b1;
            ng_n_q <= 1'b1;
        end else if (latch) begin
            s_over_n_q <= !(result_s_over && ctrl_q[`CHP_CTRL_AUX]);
            p_hi_n_q <= !result_p_hi;
            p_lo_n_q <= !result_p_lo;
            p_over_n_q <= !(result_p_hi || result_p_lo);
            ng_n_q <= !(result_p_hi || result_p_lo
                        || (result_s_over && ctrl_q[`CHP_CTRL_AUX]));
        end
    end

    // ---------------- keypad gate ----------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            key_out_q <= 1'b0;
            key_code_q <= 8'h0;
        end else begin
            key_out_q <= key_strobe && keypad_lock_n;
            if (key_strobe && keypad_lock_n) begin
                key_code_q <= key_code;
            end
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign irq = irq_int;
    assign meas_start = start_q;
    assign key_strobe_out = key_out_q;
    assign key_code_out = key_code_q;
    assign sort_bin_n = bin_n_q;
    assign secondary_over_fail_n = s_over_n_q;
    assign primary_over_fail_n = p_over_n_q;
    assign primary_upper_fail_n = p_hi_n_q;
    assign primary_lower_fail_n = p_lo_n_q;
    assign overall_fail_n = ng_n_q;
    assign conversion_busy_n = index_n_q;
    assign measure_done_n = eom_n_q;

    // ---------------- assertions ----------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_latch;
        state_q == ST_MATH && result_valid;
    endsequence

    sequence s_idle_edge;
        state_q == ST_IDLE && trig_rise;
    endsequence

    property p_bin_onehot;
        $onehot0(~bin_n_q);
    endproperty
    a_bin_onehot: assert property (p_bin_onehot)
        else $error("more than one bin output low");

    property p_bin_value;
        s_latch ##0 (result_bin == 4'h1) |=> !bin_n_q[0] && (&bin_n_q[NUM_BINS-1:1]);
    endproperty
    a_bin_value: assert property (p_bin_value)
        else $error("bin one not reported");

    property p_aux_off;
        s_latch ##0 !ctrl_q[`CHP_CTRL_AUX] |=> s_over_n_q;
    endproperty
    a_aux_off: assert property (p_aux_off)
        else $error("secondary fail shown with aux off");

    property p_sec_fail;
        s_latch ##0 (ctrl_q[`CHP_CTRL_AUX] && result_s_over) |=> !s_over_n_q && !ng_n_q;
    endproperty
    a_sec_fail: assert property (p_sec_fail)
        else $error("secondary fail not shown");

    property p_prim_limits;
        s_latch |=> (p_hi_n_q == !$past(result_p_hi)) && (p_lo_n_q == !$past(result_p_lo));
    endproperty
    a_prim_limits: assert property (p_prim_limits)
        else $error("primary limit outputs wrong");

    property p_prim_or;
        p_over_n_q == (p_hi_n_q && p_lo_n_q);
    endproperty
    a_prim_or: assert property (p_prim_or)
        else $error("primary over is not the or of high and low");

    property p_overall_or;
        ng_n_q == (s_over_n_q && p_over_n_q);
    endproperty
    a_overall_or: assert property (p_overall_or)
        else $error("overall fail is not the or of both overs");

    property p_start;
        s_idle_edge |=> !eom_n_q && !index_n_q && start_q ##1 !start_q;
    endproperty
    a_start: assert property (p_start)
        else $error("trigger edge did not start a measurement");

    property p_conv_end;
        state_q == ST_CONV && conv_done |=> index_n_q && !eom_n_q;
    endproperty
    a_conv_end: assert property (p_conv_end)
        else $error("index not released at conversion end");

    property p_busy_ignore;
        trig_req && state_q != ST_IDLE |=> $stable(meas_cnt_q) && !start_q;
    endproperty
    a_busy_ignore: assert property (p_busy_ignore)
        else $error("trigger accepted during a measurement");

    property p_done_after_hold;
        $rose(eom_n_q) |-> $past(state_q) == ST_HOLD && state_q == ST_IDLE;
    endproperty
    a_done_after_hold: assert property (p_done_after_hold)
        else $error("done released outside the hold phase");

    property p_stable_results;
        eom_n_q && $past(eom_n_q) |-> $stable(bin_n_q) && $stable(ng_n_q);
    endproperty
    a_stable_results: assert property (p_stable_results)
        else $error("results changed while idle");

    property p_key_lock;
        key_strobe && !keypad_lock_n |=> !key_out_q;
    endproperty
    a_key_lock: assert property (p_key_lock)
        else $error("key passed while keypad locked");

endmodule

// *** bench/chp_handler_model.sv ***
`timescale 1ns/1ns
module chp_handler_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // bench commands
    input wire logic fire,
    input wire logic lock_on,
    input wire logic [7:0] hold_cyc,
    // handler pins
    output logic ext_trigger_in,
    output logic keypad_lock_n
);
    logic [7:0] width_q;

    // a long hold models a slow handler; only the rising edge may start a test
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            width_q <= 8'h00;
        end else if (fire) begin
            width_q <= hold_cyc;
        end else if (width_q != 8'h00) begin
            width_q <= width_q - 8'h01;
        end
    end

    assign ext_trigger_in = (width_q != 8'h00);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            keypad_lock_n <= 1'b1;
        end else begin
            keypad_lock_n <= !lock_on;
        end
    end
endmodule

// *** bench/chp_handler_port_bench.sv ***
`timescale 1ns/1ns
`include "chp_cfg.svh"
module chp_handler_port_bench;
    import chp_pkg::*;
    localparam int BIN_DLY = 8;
    logic mclk, rst_n, avs_read, avs_write, avs_waitrequest, irq, meas_start;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic conv_done, result_valid, result_p_hi, result_p_lo, result_s_over;
    logic [3:0] result_bin;
    logic key_strobe, key_strobe_out, fire, lock_on;
    logic [7:0] key_code, key_code_out, hold_cyc;
    logic ext_trigger_in, keypad_lock_n, sec_n, pov_n, up_n, lo_n, ng_n, busy_n, done_n;
    logic [8:0] sort_bin_n, prev_bins;
    int num_errors, checked, ntrig;

    chp_handler_port #(.BIN_DLY_CYC(BIN_DLY), .NUM_BINS(9)) chp_handler_port_i (
        .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .meas_start(meas_start),
        .conv_done(conv_done), .result_valid(result_valid), .result_bin(result_bin),
        .result_p_hi(result_p_hi), .result_p_lo(result_p_lo), .result_s_over(result_s_over),
        .key_strobe(key_strobe), .key_code(key_code), .key_strobe_out(key_strobe_out),
        .key_code_out(key_code_out), .ext_trigger_in(ext_trigger_in),
        .keypad_lock_n(keypad_lock_n), .sort_bin_n(sort_bin_n),
        .secondary_over_fail_n(sec_n), .primary_over_fail_n(pov_n),
        .primary_upper_fail_n(up_n), .primary_lower_fail_n(lo_n), .overall_fail_n(ng_n),
        .conversion_busy_n(busy_n), .measure_done_n(done_n));

    chp_handler_model chp_handler_model_i (.mclk(mclk), .rst_n(rst_n), .fire(fire),
        .lock_on(lock_on), .hold_cyc(hold_cyc), .ext_trigger_in(ext_trigger_in),
        .keypad_lock_n(keypad_lock_n));

    always #20 mclk = ~mclk;

    task automatic complete_run;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one access; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        int n;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        for (n = 0; n < 20; n++) begin
            @(posedge mclk);
            if (avs_waitrequest === 1'b0) break;
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 20) begin
            num_errors++;
            complete_run;
        end
    endtask

    task automatic wait_start(input int lim, output logic seen);
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            @(posedge mclk);
            #1;
            seen = (meas_start === 1'b1);
        end
    endtask

    task automatic pulse_fire(input logic [7:0] hold);
        @(posedge mclk);
        fire <= 1'b1;
        hold_cyc <= hold;
        @(posedge mclk);
        fire <= 1'b0;
    endtask

    task automatic measure(input logic [3:0] bin, input logic hi, input logic lo,
                           input logic so, input logic aux, input logic poke,
                           input logic [7:0] hold);
        logic [8:0] eb;
        logic seen, sf;
        int n;
        eb = (bin >= 4'h1 && bin <= 4'h9) ? ~(9'h001 << (bin - 4'h1)) : 9'h1ff;
        sf = so & aux;
        bus(1'b1, `CHP_REG_CTRL, {30'h0, 1'b1, aux}, q);
        pulse_fire(hold);
        wait_start(8, seen);
        chk("meas_start", 1, seen);
        chk("bins_kept", prev_bins, sort_bin_n);
        chk("busy_at_start", 0, busy_n);
        chk("done_at_start", 0, done_n);
        ntrig++;
        if (poke) begin
            pulse_fire(8'h01);
            wait_start(6, seen);
            chk("retrigger", 0, seen);
        end
        @(posedge mclk);
        #1;
        chk("busy_conv", 0, busy_n);
        @(posedge mclk);
        conv_done <= 1'b1;
        @(posedge mclk);
        conv_done <= 1'b0;
        @(posedge mclk);
        #1;
        chk("busy_after", 1, busy_n);
        chk("done_math", 0, done_n);
        result_bin <= bin;
        result_p_hi <= hi;
        result_p_lo <= lo;
        result_s_over <= so;
        result_valid <= 1'b1;
        @(posedge mclk);
        result_valid <= 1'b0;
        @(posedge mclk);
        #1;
        chk("bins", eb, sort_bin_n);
        chk("upper", !hi, up_n);
        chk("lower", !lo, lo_n);
        chk("p_over", !(hi | lo), pov_n);
        chk("s_over", !sf, sec_n);
        chk("overall", !(hi | lo | sf), ng_n);
        chk("done_hold", 0, done_n);
        for (n = 0; n < 200 && done_n !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        if (n >= 200) begin
            num_errors++;
            complete_run;
        end
        chk("done_delay", 1, n >= BIN_DLY - 2 && n <= BIN_DLY + 2);
        chk("bins_stable", eb, sort_bin_n);
        chk("overall_stable", !(hi | lo | sf), ng_n);
        prev_bins = eb;
    endtask

    task automatic test_reset;
        chk("bins_rst", 9'h1ff, sort_bin_n);
        chk("fails_rst", 5'h1f, {sec_n, pov_n, up_n, lo_n, ng_n});
        chk("status_rst", 3'h7, {busy_n, done_n, !irq});
        bus(1'b0, `CHP_REG_CTRL, 32'h0, q);
        chk("ctrl_rst", 32'h2, q);
        bus(1'b0, `CHP_REG_IRQ_MASK, 32'h0, q);
        chk("mask_rst", 32'h0, q);
        bus(1'b0, `CHP_REG_STATUS, 32'h0, q);
        chk("status_idle", 32'h0, q);
        bus(1'b1, `CHP_REG_RESULT, 32'hff, q);
        bus(1'b0, `CHP_REG_RESULT, 32'h0, q);
        chk("result_ro", 32'h0, q);
        bus(1'b0, 5'h18, 32'h0, q);
        chk("unmapped", 32'h0, q);
    endtask

    task automatic test_keys;
        @(posedge mclk);
        key_strobe <= 1'b1;
        key_code <= 8'h5a;
        @(posedge mclk);
        key_strobe <= 1'b0;
        #1;
        chk("key_pass", 9'h15a, {key_strobe_out, key_code_out});
        lock_on <= 1'b1;
        repeat (2) @(posedge mclk);
        key_strobe <= 1'b1;
        key_code <= 8'ha5;
        @(posedge mclk);
        key_strobe <= 1'b0;
        #1;
        chk("key_locked", 0, key_strobe_out);
        bus(1'b0, `CHP_REG_IRQ_STAT, 32'h0, q);
        chk("key_refused", 1, q[`CHP_EVT_KEY_REF]);
        lock_on <= 1'b0;
    endtask

    task automatic test_irq;
        bus(1'b1, `CHP_REG_IRQ_MASK, 32'h0, q);
        bus(1'b1, `CHP_REG_IRQ_STAT, 32'h1f, q);
        measure(4'h9, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h01);
        repeat (2) @(posedge mclk);
        #1;
        chk("irq_masked", 0, irq);
        bus(1'b0, `CHP_REG_IRQ_STAT, 32'h0, q);
        chk("evt_done", 1, q[`CHP_EVT_DONE]);
        bus(1'b1, `CHP_REG_IRQ_MASK, 32'h4, q);
        repeat (2) @(posedge mclk);
        #1;
        chk("irq_on", 1, irq);
        bus(1'b1, `CHP_REG_IRQ_STAT, 32'h4, q);
        repeat (2) @(posedge mclk);
        #1;
        chk("irq_cleared", 0, irq);
    endtask

    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        {avs_read, avs_write, conv_done, result_valid, key_strobe, fire, lock_on} = 7'h00;
        {result_p_hi, result_p_lo, result_s_over} = 3'h0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        result_bin = 4'h0;
        key_code = 8'h00;
        hold_cyc = 8'h01;
        prev_bins = 9'h1ff;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        test_reset;
        for (int i = 0; i < 11; i++) begin
            measure(i[3:0], i % 3 == 1, i % 3 == 2, i[0], i[1], 1'b0, (i == 4) ? 8'h06 : 8'h01);
        end
        bus(1'b1, `CHP_REG_IRQ_STAT, 32'h1f, q);
        measure(4'h3, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 8'h01);
        bus(1'b0, `CHP_REG_IRQ_STAT, 32'h0, q);
        chk("trig_ignored", 1, q[`CHP_EVT_TRIG_IGN]);
        bus(1'b0, `CHP_REG_COUNT, 32'h0, q);
        chk("count", ntrig, q);
        test_keys;
        test_irq;
        complete_run;
    end
endmodule
